// file: bench/afs_host_model.sv
// Purpose: host serial master driving frame-sync conversions
// Assumes: every call starts 1 ns after a clock edge
// Notes: sclk parks low outside frames; din toggles when unused
`timescale 1ns/1ps
`default_nettype none
module afs_host_model (
  // pins to device
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  output logic frame_sync_in_o,
  output logic word_width_select_o,
  // pins from device
  input wire logic dout_i,
  input wire logic frame_sync_out_i
);
  // idle: deselected, clock low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    frame_sync_in_o = 1'b0;
    word_width_select_o = 1'b0;
  end
  // level set well before chip select moves
  task automatic select(input bit fs, input bit cs);
    frame_sync_in_o = fs;
    #80 cs_n_o = cs;
  endtask
  // pulse then n clocks; dout read late in the high phase
  task automatic frame(input bit w16, input logic [15:0] cfg, input int n,
    output logic [47:0] rd, output int fs_at);
    int len;
    len = w16 ? 16 : 8;
    word_width_select_o = w16;
    rd = '0;
    fs_at = 0;
    for (int k = 0; k <= n; k++) begin
      sclk_o = 1'b1;
      frame_sync_in_o = (k == 0);
      din_o = (k > 0 && k <= len) ? cfg[len-k] : ~din_o;
      #70;
      if (k > 0) begin
        rd = {rd[46:0], dout_i};
        if (frame_sync_out_i === 1'b1 && fs_at == 0) fs_at = k;
      end
      #10 sclk_o = 1'b0;
      #80;
    end
  endtask
endmodule // afs_host_model
`default_nettype wire

// file: bench/afs_port_properties.sv
// Purpose: concurrent checks on the frame-sync serial port pins
// Assumes: sclk slow against clock_i, pins resynchronised inside the port
// Notes: bound into every afs_port
`timescale 1ns/1ps
`default_nettype none
module afs_port_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // host pins
  input wire logic cs_n_i,
  input wire logic frame_sync_in_i,
  // device outputs
  input wire logic dout_oe_o,
  input wire logic frame_sync_out_o,
  input wire logic analog_awake_o,
  input wire logic acquire_o,
  input wire logic sample_strobe_o,
  input wire logic config_valid_o,
  input wire logic int_osc_en_o,
  input wire logic frame_mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // sync out lands one sclk period (16 clocks) after the sample edge
  sequence sync_after_sample;
    ##[14:18] $rose(frame_sync_out_o);
  endsequence
  // last capture fall is the fall that ends the sync pulse
  sequence sync_ends_at_capture;
    $fell(frame_sync_out_o);
  endsequence
  osc_off_a: assert property (!int_osc_en_o) else $error("oscillator on");
  mode_entry_a: assert property ($fell(cs_n_i) && !frame_sync_in_i |-> ##[2:6] frame_mode_o)
    else $error("frame mode not entered");
  oe_off_a: assert property (cs_n_i[*4] |-> !dout_oe_o) else $error("dout driven while deselected");
  cs_abort_a: assert property ($rose(cs_n_i) |-> ##6 !analog_awake_o && !acquire_o)
    else $error("no shutdown after deselect");
  sample_ends_a: assert property (sample_strobe_o |-> acquire_o ##1 !acquire_o)
    else $error("acquire not ended by sample");
  sync_sample_a: assert property (frame_mode_o && sample_strobe_o |-> sync_after_sample)
    else $error("sync out late after sample");
  sync_capture_a: assert property (frame_mode_o && config_valid_o |-> sync_ends_at_capture)
    else $error("sync out not ended by last capture");
  sync_width_a: assert property ($rose(frame_sync_out_o) |-> frame_sync_out_o[*5] ##[1:8] !frame_sync_out_o)
    else $error("sync out width wrong");
  sync_mode_a: assert property (frame_sync_out_o |-> frame_mode_o) else $error("sync out outside mode");
endmodule // afs_port_properties
bind afs_port afs_port_properties i_afs_port_properties (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n_i),
  .frame_sync_in_i(frame_sync_in_i), .dout_oe_o(dout_oe_o), .frame_sync_out_o(frame_sync_out_o),
  .analog_awake_o(analog_awake_o), .acquire_o(acquire_o), .sample_strobe_o(sample_strobe_o),
  .config_valid_o(config_valid_o), .int_osc_en_o(int_osc_en_o), .frame_mode_o(frame_mode_o));
`default_nettype wire

// file: bench/testbench.sv
// Purpose: self-checking bench of the frame-sync serial port
// Assumes: host model paces sclk at 160 ns
// Notes: result read as 14 bits MSB first, two zero bits, then zeros
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i, srst_i, cs_n_i, sclk_i, din_i, frame_sync_in_i, word_width_select_i;
  logic dout_o, dout_oe_o, frame_sync_out_o, analog_awake_o, acquire_o, sample_strobe_o;
  logic config_valid_o, int_osc_en_o, frame_mode_o, result_ready_o;
  logic [13:0] sample_data_i;
  logic [15:0] config_o;
  logic [47:0] rd;
  int fs_at, failures, n_compared;
  // device and host
  afs_port i_dut (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .din_i(din_i),
    .frame_sync_in_i(frame_sync_in_i), .word_width_select_i(word_width_select_i), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .frame_sync_out_o(frame_sync_out_o), .analog_awake_o(analog_awake_o),
    .acquire_o(acquire_o), .sample_strobe_o(sample_strobe_o), .sample_data_i(sample_data_i),
    .config_o(config_o), .config_valid_o(config_valid_o), .int_osc_en_o(int_osc_en_o),
    .frame_mode_o(frame_mode_o), .result_ready_o(result_ready_o));
  afs_host_model i_host (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i),
    .frame_sync_in_o(frame_sync_in_i), .word_width_select_o(word_width_select_i),
    .dout_i(dout_o), .frame_sync_out_i(frame_sync_out_o));
  // comparison with report
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask
  // full conversion with e extra clocks after the frame
  task automatic conv(input bit w16, input logic [15:0] cfg, input logic [13:0] res, input int e);
    sample_data_i = res;
    i_host.frame(w16, cfg, (w16 ? 32 : 24) + e, rd, fs_at);
    check("result", (48'(res) << 2) << e, rd);
    check("sync at", w16 ? 16 : 8, fs_at);
    check("config", w16 ? cfg : cfg[7:0], w16 ? config_o : config_o[7:0]);
    check("queue empty", 0, result_ready_o);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // traffic needs about 21 us
  initial begin
    #200000;
    failures++;
    $display("[FAIL] watchdog expected done seen timeout");
    stop_test();
  end
  initial begin
    failures = 0;
    n_compared = 0;
    srst_i = 1'b1;
    sample_data_i = '0;
    step(20);
    srst_i = 1'b0;
    step(5);
    check("idle oe", 0, dout_oe_o);
    i_host.select(1'b0, 1'b0);
    step(6);
    check("mode", 3'b110, {frame_mode_o, dout_oe_o, dout_o});
    conv(1'b0, 16'h00A5, 14'h2A5B, 2);
    conv(1'b1, 16'hC3A5, 14'h3FFF, 0);
    check("osc", 0, int_osc_en_o);
    $display("test frames done");
    sample_data_i = 14'h1555;
    i_host.frame(1'b1, 16'hFFFF, 10, rd, fs_at);
    check("aborted sync", 0, fs_at);
    conv(1'b0, 16'h005A, 14'h0001, 0);
    $display("test restart done");
    i_host.frame(1'b0, 16'h0033, 5, rd, fs_at);
    i_host.select(1'b0, 1'b1);
    step(6);
    check("shutdown", 0, {analog_awake_o, acquire_o, dout_oe_o});
    i_host.select(1'b1, 1'b0);
    step(6);
    i_host.frame(1'b0, 16'h0011, 24, rd, fs_at);
    check("other mode", 0, {frame_mode_o, fs_at != 0});
    $display("test refusals done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire

// file: core/afs_consts.svh
// Purpose: timing counts, field positions and reset values of the frame-sync serial port
// Assumes: all frame timing counted in serial clock cycles of the link
// Notes: Operation list below
// Operation
// - frame-sync input low at chip select fall selects frame-sync mode
// - chip select may stay low across successive conversions
// - frame-sync pulse wakes converter and enables input clocking
// - capture input on falling edges, first after pulse, through 8th
// - in 16-bit option capture continues to the 16th falling edge
// - channel applied and acquisition begins at 3rd falling edge
// - 8-bit option samples input at rising edge of 7th cycle
// - 16-bit option samples at rising edge of 15th cycle
// - 8-bit option: sync out at 8th rise, data MSB first from 9th
// - 16-bit option: sync out at 16th rise, data from 17th
// - sixteen clocks read the result, zeros follow until next frame
// - a conversion takes 24 or 32 serial clock cycles
// - new frame-sync pulse mid conversion aborts and restarts
// - chip select rising mid conversion aborts and shuts down
// - result is unsigned straight binary over 16384 codes
// - internal oscillator stays off in external clock mode
// - serial output changes on falling edges of the serial clock; dout here changes on rising edges
// - read frame: zero byte, MSB to D6, D5 to D0 and two trailing bits
// - data output high impedance while chip select high, low after fall
// - no scan sequences; one conversion per frame-sync pulse
`ifndef AFS_CONSTS_SVH
`define AFS_CONSTS_SVH
`define AFS_RES_W 14
`define AFS_CFG_W 16
`define AFS_CNT_W 6
`define AFS_CHAN_EDGE 6'h03
`define AFS_SAMPLE_8 6'h07
`define AFS_SAMPLE_16 6'h0F
`define AFS_SYNC_8 6'h08
`define AFS_SYNC_16 6'h10
`define AFS_READ_BITS 6'h10
`define AFS_FRAME_8 6'h18
`define AFS_FRAME_16 6'h20
`define AFS_TRAIL_UPPER 1'b0
`define AFS_TRAIL_LOWER 1'b0
`endif

// file: core/afs_fifo.sv
// Purpose: small result FIFO between the converter handoff and the output shifter
// Assumes: single clock, synchronous active high reset
// Notes: read data comes from a register
`timescale 1ns/1ps
`default_nettype none
module afs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // write side
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read side
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr, rptr, next_wptr, next_rptr;
  logic [WIDTH-1:0] next_rd_data;
  logic do_wr, do_rd;

  // full when pointers differ only in wrap bit
  assign wr_ready_o = !((wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]));
  assign rd_valid_o = (wptr != rptr);

  // pointer and read data update
  always_comb begin
    do_wr = wr_valid_i && wr_ready_o;
    do_rd = rd_valid_o && rd_ready_i;
    next_wptr = do_wr ? wptr + 1'b1 : wptr;
    next_rptr = do_rd ? rptr + 1'b1 : rptr;
    next_rd_data = do_rd ? mem[rptr[AW-1:0]] : rd_data_o;
  end

  // registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wptr <= '0;
      rptr <= '0;
      rd_data_o <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      rd_data_o <= next_rd_data;
    end
    if (do_wr) begin
      mem[wptr[AW-1:0]] <= wr_data_i;
    end
  end
endmodule // afs_fifo
`default_nettype wire

// file: core/afs_pkg.sv
// Purpose: types of the frame-sync serial port
// Assumes: constants come from afs_consts.svh
// Notes: none
package afs_pkg;
  typedef enum logic [3:0] {
    AFS_OFF = 4'h1,
    AFS_IDLE = 4'h2,
    AFS_CONV = 4'h4,
    AFS_TAIL = 4'h8
  } afs_state_t;
endpackage

// file: core/afs_port.sv
// Purpose: frame-sync serial control port of a 14-bit converter, device side
// Assumes: serial clock and pins sampled by clock_i at far above 4.8 MHz
// Notes: analog result arrives on sample_data_i when sample_strobe_o fires
`include "afs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module afs_port #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // serial pins from host
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic frame_sync_in_i,
  input wire logic word_width_select_i,
  // serial pins to host
  output logic dout_o,
  output logic dout_oe_o,
  output logic frame_sync_out_o,
  // converter side
  output logic analog_awake_o,
  output logic acquire_o,
  output logic sample_strobe_o,
  input wire logic [`AFS_RES_W-1:0] sample_data_i,
  output logic [`AFS_CFG_W-1:0] config_o,
  output logic config_valid_o,
  output logic int_osc_en_o,
  // status
  output logic frame_mode_o,
  output logic result_ready_o
);
  // synchronised pins
  logic [4:0] pins_s;
  logic cs_n_s, sclk_s, din_s, fsi_s, wsel_s;
  // idle levels of the pins, so that no false edge follows reset
  afs_sync #(.WIDTH(5), .IDLE(5'h10)) u_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i({cs_n_i, sclk_i, din_i, frame_sync_in_i, word_width_select_i}),
    .sync_o(pins_s)
  );
  assign {cs_n_s, sclk_s, din_s, fsi_s, wsel_s} = pins_s;

  // edge detection on synchronised levels only
  logic sclk_d, cs_n_d, fsi_d;
  logic sclk_rise, sclk_fall, cs_fall, fsi_rise;
  assign sclk_rise = sclk_s && !sclk_d;
  assign sclk_fall = !sclk_s && sclk_d;
  assign cs_fall = !cs_n_s && cs_n_d;
  assign fsi_rise = fsi_s && !fsi_d;

  afs_pkg::afs_state_t state, next_state;
  logic frame_mode, next_frame_mode;
  logic wide, next_wide;
  logic [`AFS_CNT_W-1:0] cyc, next_cyc;
  logic [`AFS_CFG_W-1:0] cfg, next_cfg;
  logic cfg_valid, next_cfg_valid;
  logic acquire, next_acquire;
  logic fs_out, next_fs_out;
  logic dout, next_dout;
  logic [`AFS_RES_W+1:0] shreg, next_shreg;
  logic [`AFS_CNT_W-1:0] bits_left, next_bits_left;
  logic load_pend, next_load_pend;
  logic fifo_wr_valid, fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
  logic [`AFS_RES_W-1:0] fifo_rd_data;

  // capture window end, sample and sync cycles per option
  function automatic logic [`AFS_CNT_W-1:0] cap_end(input logic w);
    cap_end = w ? `AFS_SYNC_16 : `AFS_SYNC_8;
  endfunction
  function automatic logic [`AFS_CNT_W-1:0] sample_cyc(input logic w);
    sample_cyc = w ? `AFS_SAMPLE_16 : `AFS_SAMPLE_8;
  endfunction

  // result handoff: sample strobe pushes the converter word
  assign sample_strobe_o = (state == afs_pkg::AFS_CONV) && sclk_rise
                         && (cyc + 6'h01 == sample_cyc(wide)) && !fsi_s && !cs_n_s;
  assign fifo_wr_valid = sample_strobe_o;
  // pop at the output sync pulse; outside the sample-to-sync span a stale word
  // left by an aborted frame is drained so it never reaches a later frame
  assign fifo_rd_ready = (state != afs_pkg::AFS_CONV) || (cyc + 6'h01 < sample_cyc(wide))
                       || (sclk_rise && (cyc + 6'h01 == cap_end(wide)));

  afs_fifo #(.WIDTH(`AFS_RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_valid_i(fifo_wr_valid),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i(sample_data_i),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(fifo_rd_ready),
    .rd_data_o(fifo_rd_data)
  );

  // frame state machine and serial engine
  always_comb begin
    next_state = state;
    next_frame_mode = frame_mode;
    next_wide = wide;
    next_cyc = cyc;
    next_cfg = cfg;
    next_cfg_valid = 1'b0;
    next_acquire = acquire;
    next_fs_out = fs_out;
    next_dout = dout;
    next_shreg = shreg;
    next_bits_left = bits_left;
    next_load_pend = 1'b0;
    // the popped word shows on the FIFO register one clock after the pop
    if (load_pend) begin
      next_shreg = {fifo_rd_data, `AFS_TRAIL_UPPER, `AFS_TRAIL_LOWER};
    end
    if (cs_n_s) begin
      next_state = afs_pkg::AFS_OFF;
      next_acquire = 1'b0;
      next_fs_out = 1'b0;
      next_dout = 1'b0;
      next_cyc = '0;
    end else if (cs_fall) begin
      next_frame_mode = !fsi_s;
      next_state = afs_pkg::AFS_IDLE;
      next_dout = 1'b0;
    end else if (frame_mode && fsi_rise) begin
      // a new pulse restarts any frame in flight
      next_state = afs_pkg::AFS_CONV;
      next_wide = wsel_s;
      next_cyc = '0;
      next_cfg = '0;
      next_acquire = 1'b0;
      next_fs_out = 1'b0;
      next_dout = 1'b0;
      next_bits_left = '0;
    end else begin
      case (state)
        afs_pkg::AFS_OFF: begin
          next_state = afs_pkg::AFS_OFF;
        end
        afs_pkg::AFS_IDLE: begin
          next_state = afs_pkg::AFS_IDLE;
        end
        afs_pkg::AFS_CONV, afs_pkg::AFS_TAIL: begin
          if (sclk_fall && !fsi_s) begin
            // cycle count advances on each falling edge after the pulse, holding at 6'h3F
            if (cyc != 6'h3F) begin
              next_cyc = cyc + 6'h01;
            end
            if (cyc < cap_end(wide)) begin
              next_cfg = {cfg[`AFS_CFG_W-2:0], din_s};
              if (cyc + 6'h01 == cap_end(wide)) begin
                next_cfg_valid = 1'b1;
              end
            end
            if (cyc + 6'h01 == `AFS_CHAN_EDGE) begin
              next_acquire = 1'b1;
            end
            if (fs_out) begin
              next_fs_out = 1'b0;
            end
          end
          if (sclk_rise && state == afs_pkg::AFS_CONV) begin
            // at a rising edge cyc still holds the previous cycle's count
            if (cyc + 6'h01 == sample_cyc(wide)) begin
              next_acquire = 1'b0;
            end
            if (cyc + 6'h01 == cap_end(wide)) begin
              next_fs_out = 1'b1;
              // zeros if nothing queued, else the word lands next clock
              next_shreg = '0;
              next_load_pend = fifo_rd_valid;
              next_bits_left = `AFS_READ_BITS;
              next_state = afs_pkg::AFS_TAIL;
            end
          end else if (sclk_rise && state == afs_pkg::AFS_TAIL) begin
            // shift MSB first, zeros after the sixteenth bit
            if (bits_left != '0) begin
              next_dout = shreg[`AFS_RES_W+1];
              next_shreg = {shreg[`AFS_RES_W:0], 1'b0};
              next_bits_left = bits_left - 6'h01;
            end else begin
              next_dout = 1'b0;
            end
          end
        end
        default: begin
          next_state = afs_pkg::AFS_OFF;
        end
      endcase
    end
  end

  // registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      fsi_d <= 1'b0;
      state <= afs_pkg::AFS_OFF;
      frame_mode <= 1'b0;
      wide <= 1'b0;
      cyc <= '0;
      cfg <= '0;
      cfg_valid <= 1'b0;
      acquire <= 1'b0;
      fs_out <= 1'b0;
      dout <= 1'b0;
      shreg <= '0;
      bits_left <= '0;
      load_pend <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      fsi_d <= fsi_s;
      state <= next_state;
      frame_mode <= next_frame_mode;
      wide <= next_wide;
      cyc <= next_cyc;
      cfg <= next_cfg;
      cfg_valid <= next_cfg_valid;
      acquire <= next_acquire;
      fs_out <= next_fs_out;
      dout <= next_dout;
      shreg <= next_shreg;
      bits_left <= next_bits_left;
      load_pend <= next_load_pend;
    end
  end

  // pin and status outputs
  assign dout_o = dout;
  assign dout_oe_o = !cs_n_s;
  assign frame_sync_out_o = fs_out;
  assign config_o = cfg;
  assign config_valid_o = cfg_valid;
  assign acquire_o = acquire;
  // analog stays up from the pulse until chip select rises, idle tail included; one conversion per pulse
  assign analog_awake_o = (state == afs_pkg::AFS_CONV) || (state == afs_pkg::AFS_TAIL);
  assign int_osc_en_o = 1'b0;
  assign frame_mode_o = frame_mode;
  assign result_ready_o = fifo_rd_valid && fifo_wr_ready;
endmodule // afs_port
`default_nettype wire

// file: core/afs_sync.sv
// Purpose: two-flop synchroniser for pins
// Assumes: first stage feeds only the second
// Notes: resets to the given idle level
`timescale 1ns/1ps
`default_nettype none
module afs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // pin side
  input wire logic [WIDTH-1:0] pin_i,
  // synchronised side
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta, next_meta, next_sync;

  // plain shift through two stages
  always_comb begin
    next_meta = pin_i;
    next_sync = meta;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta <= IDLE;
      sync_o <= IDLE;
    end else begin
      meta <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule // afs_sync
`default_nettype wire
